/* File: dv/ocp_pin_load.sv */
`timescale 1ns/1ns
// external circuit on the compare pin; also owns the fault line
module ocp_pin_load (
    input  wire logic       clk_i,
    input  wire logic       pin_i,        // compare output pin level
    input  wire logic       fault_req_i,  // bench asks for a fault
    output logic            fault_n_o,    // fault line, active low
    output logic [7:0]      rise_cnt_o    // clean rising edges seen
);
    logic       pin_q = 1'b1;  // starts high so reset never counts as an edge
    logic [7:0] cnt_r = 8'h00; // clean rising edges so far
    // fault line idles high and is only pulled low on request
    assign fault_n_o = !fault_req_i;
    // count only clean 0 to 1 moves; unknowns are never counted
    always @(posedge clk_i) begin
        if (pin_q === 1'b0 && pin_i === 1'b1) begin
            cnt_r <= cnt_r + 8'h01;
        end
        pin_q <= pin_i;
    end
    assign rise_cnt_o = cnt_r;
endmodule : ocp_pin_load

/* File: dv/output_compare_pwm_test.sv */
`timescale 1ns/1ns
// bench: wishbone register calls plus timer steps, checked at the pins
module output_compare_pwm_test;
    localparam logic [4:0] A_CTL = ocp_pkg::ADDR_CONTROL;
    localparam logic [4:0] A_PRI = ocp_pkg::ADDR_PRIMARY;
    localparam logic [4:0] A_SEC = ocp_pkg::ADDR_SECONDARY;
    localparam logic [4:0] A_ST  = ocp_pkg::ADDR_STATUS;
    localparam logic [4:0] A_MSK = ocp_pkg::ADDR_MASK;  // mask register
    localparam logic [4:0] A_BAD = 5'h14;  // nothing mapped here
    logic        clk_i, rst_i, cyc, stb, we, ack, pin, irq;
    logic        fault_n, fault_req, idle, gpio;
    logic [4:0]  adr;
    logic [3:0]  sel;      // byte lanes of the request
    logic [31:0] wdat, rdat, q;
    logic [15:0] ta, tb;   // the two timer counts
    logic [7:0]  rises;    // edge count from the load model
    int          num_errors = 0, tests_run = 0, cycles = 0;

    ocp_compare #(.TW(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .timer_a_i(ta), .timer_b_i(tb), .cpu_idle_i(idle),
        .fault_input_a_n_i(fault_n), .gpio_out_i(gpio), .compare_output_pin_o(pin), .irq_o(irq));
    ocp_pin_load u_load (.clk_i(clk_i), .pin_i(pin), .fault_req_i(fault_req),
        .fault_n_o(fault_n), .rise_cnt_o(rises));

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // hang guard; the whole run needs well under 3000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task chk_reg(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk_reg
    task chk_bit(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", name, e, g);
        end
    endtask : chk_bit
    // one classic cycle; held until ack is sampled, then released
    // only the hang guard ends a wait; ack is registered, so it is seen at the second edge
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        chk_reg("wb_latency", 32'h2, 32'(n));
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask : wb
    task rd(input logic [4:0] a, input string name, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk_reg(name, e, q);
    endtask : rd
    // timers show a value for one cycle, then park where nothing matches
    task step(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_i);
        ta <= a;
        tb <= b;
        @(posedge clk_i);
        ta <= 16'hffff;
        tb <= 16'hffff;
        repeat (3) @(posedge clk_i);
    endtask : step
    task settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // timers stay parked during every control write
    initial begin
        {cyc, stb, we, idle, gpio, fault_req} = 6'h0;
        sel = 4'h0;
        adr = 5'h0;
        wdat = 32'h0;
        ta = 16'hffff;
        tb = 16'hffff;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_CTL, "control", {16'h0, ocp_pkg::CTL_RESET});
        rd(A_BAD, "unmapped", 32'h0);
        wb(1'b1, A_PRI, 32'h0);
        wb(1'b1, A_CTL, 32'hffff);
        rd(A_CTL, "control", {16'h0, ocp_pkg::CTL_WR_MASK});
        wb(1'b1, A_PRI, 32'h5);
        wb(1'b1, A_SEC, 32'h9);
        wb(1'b1, A_MSK, 32'h3);
        wb(1'b1, A_CTL, 32'h1);
        settle();
        chk_bit("pin", 1'b0, pin);
        step(16'h5, 16'h5);
        chk_bit("pin", 1'b1, pin);
        rd(A_ST, "status", 32'h1);
        chk_bit("irq", 1'b1, irq);
        wb(1'b1, A_ST, 32'h1);
        settle();
        chk_bit("irq", 1'b0, irq);
        // masked event still latches but keeps irq low
        wb(1'b1, A_MSK, 32'h0);
        wb(1'b1, A_CTL, 32'h2);
        settle();
        chk_bit("pin", 1'b1, pin);
        step(16'h5, 16'h5);
        chk_bit("pin", 1'b0, pin);
        rd(A_ST, "status", 32'h1);
        chk_bit("irq", 1'b0, irq);
        wb(1'b1, A_ST, 32'h1);
        wb(1'b1, A_MSK, 32'h3);
        // toggle on the second timer only
        wb(1'b1, A_CTL, 32'hb);
        settle();
        chk_bit("pin", 1'b0, pin);
        step(16'h5, 16'hffff);
        chk_bit("pin", 1'b0, pin);
        step(16'hffff, 16'h5);
        chk_bit("pin", 1'b1, pin);
        rd(A_ST, "status", 32'h1);
        wb(1'b1, A_ST, 32'h1);
        wb(1'b1, A_CTL, 32'h200b);
        idle <= 1'b1;
        step(16'hffff, 16'h5);
        chk_bit("pin", 1'b1, pin);
        idle <= 1'b0;
        step(16'hffff, 16'h5);
        chk_bit("pin", 1'b0, pin);
        rd(A_ST, "status", 32'h1);
        wb(1'b1, A_ST, 32'h1);
        // delayed and continuous pulses: primary raises, secondary lowers
        for (int m = 4; m < 6; m++) begin
            wb(1'b1, A_CTL, 32'(m));
            settle();
            chk_bit("pin", 1'b0, pin);
            step(16'h5, 16'h5);
            chk_bit("pin", 1'b1, pin);
            rd(A_ST, "status", 32'h0);
            step(16'h9, 16'h9);
            chk_bit("pin", 1'b0, pin);
            rd(A_ST, "status", 32'h1);
            wb(1'b1, A_ST, 32'h1);
            // delayed gives one pulse only, continuous raises again
            step(16'h5, 16'h5);
            chk_bit("pin", m == 5, pin);
        end
        wb(1'b1, A_CTL, 32'h6);
        settle();
        chk_bit("pin", 1'b1, pin);
        step(16'h5, 16'h5);
        chk_bit("pin", 1'b0, pin);
        step(16'h0, 16'h0);
        chk_bit("pin", 1'b1, pin);
        rd(A_ST, "status", 32'h0);
        wb(1'b1, A_CTL, 32'h0);
        wb(1'b1, A_PRI, 32'h0);
        wb(1'b1, A_CTL, 32'h6);
        settle();
        chk_bit("pin", 1'b0, pin);
        // disabled: pin follows the port level, matches ignored
        wb(1'b1, A_CTL, 32'h0);
        gpio <= 1'b1;
        step(16'h0, 16'h0);
        chk_bit("pin", 1'b1, pin);
        gpio <= 1'b0;
        settle();
        chk_bit("pin", 1'b0, pin);
        rd(A_ST, "status", 32'h0);
        // protected pwm with a fault in mid-period
        wb(1'b1, A_PRI, 32'h5);
        wb(1'b1, A_CTL, 32'h7);
        settle();
        chk_bit("pin", 1'b1, pin);
        fault_req <= 1'b1;
        settle();
        chk_bit("pin", 1'b0, pin);
        rd(A_CTL, "control", 32'h17);
        rd(A_ST, "status", 32'h2);
        chk_bit("irq", 1'b1, irq);
        fault_req <= 1'b0;
        settle();
        rd(A_CTL, "control", 32'h7);
        wb(1'b1, A_ST, 32'h2);
        settle();
        chk_bit("irq", 1'b0, irq);
        chk_reg("pin_rises", 32'h8, {24'h0, rises});
        report_and_stop();
    end
endmodule : output_compare_pwm_test

/* File: rtl/ocp_compare.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - one of two 16-bit timers is time base
// - compare against one or two values per mode
// - match changes pin as mode defines
// - interrupts on mode-selected compare events
// - mode 000 off, pin to gpio, no irq
// - one-shot, delayed, continuous pulse start and irq
// - toggle keeps level, inverts on match, both edges
// - plain pwm starts by primary zero, no irq
// - fault pwm same start, irq on fault fall
// - control 16 bits, bits 13,4,3,2:0 only
module ocp_compare #(
    parameter int TW = 16  // timer and compare width
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // classic wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [4:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // time bases and environment
    input  wire logic [TW-1:0] timer_a_i,   // first timer count
    input  wire logic [TW-1:0] timer_b_i,   // second timer count
    input  wire logic          cpu_idle_i,  // cpu idle state
    input  wire logic          fault_input_a_n_i, // fault input, active low
    input  wire logic          gpio_out_i,  // pin level while disabled
    output logic               compare_output_pin_o,
    output logic               irq_o
);
    // byte offsets of the register map, at the decoder width
    localparam logic [4:0] A_CTL = ocp_pkg::ADDR_CONTROL;
    localparam logic [4:0] A_PRI = ocp_pkg::ADDR_PRIMARY;
    localparam logic [4:0] A_SEC = ocp_pkg::ADDR_SECONDARY;
    localparam logic [4:0] A_STS = ocp_pkg::ADDR_STATUS;
    localparam logic [4:0] A_MSK = ocp_pkg::ADDR_MASK;

    ocp_pkg::ocp_ctl_t ctl_r, ctl_nxt;         // control register
    logic [TW-1:0]     pri_r, pri_nxt;         // primary compare value
    logic [TW-1:0]     sec_r, sec_nxt;         // secondary compare value
    logic [1:0]        sts_r, sts_nxt;         // sticky events
    logic [1:0]        msk_r, msk_nxt;         // interrupt enables
    logic              ack_r, ack_nxt;         // bus answer
    logic [31:0]       dat_r, dat_nxt;         // read data
    logic              pin_r, pin_nxt;         // driven compare level
    logic              done_r, done_nxt;       // one-shot finished
    logic              init_r, init_nxt;       // first cycle of a mode
    logic [2:0]        mode_prev_r;            // mode last cycle, for entry detect
    logic              fault_r;                // fault level last cycle
    logic [TW-1:0]     tmr;                    // selected time base
    logic              run;                    // channel clocks
    logic              hit_pri, hit_sec;       // compare matches
    logic              pin_rise, pin_fall;     // pin edges
    logic              ev_match, ev_fault;     // interrupt events
    logic              req, wr, rd;
    logic              entry;                  // mode changed this cycle
    logic              fault_act;              // fault asserted in fault pwm

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;

    // time base choice: select high takes the second timer
    assign tmr = ctl_r.timebase_select ? timer_b_i : timer_a_i;
    // halting in idle freezes the compare engine
    assign run = ~(ctl_r.idle_halt & cpu_idle_i);
    // secondary compare only matters in the two-value modes
    assign hit_pri = run & (tmr == pri_r);
    assign hit_sec = run & (tmr == sec_r) &
                     (ctl_r.mode inside {ocp_pkg::OCP_DELAYED, ocp_pkg::OCP_CONT});
    assign entry     = (ctl_r.mode != mode_prev_r);
    assign fault_act = (ctl_r.mode == ocp_pkg::OCP_PWM_FLT) & ~fault_input_a_n_i;

    // pin engine: initial level on entry, then match-driven changes
    always_comb begin
        pin_nxt  = pin_r;
        done_nxt = done_r;
        init_nxt = 1'b0;
        if (entry) begin
            init_nxt = 1'b1;
            done_nxt = 1'b0;
            unique case (ctl_r.mode)
                ocp_pkg::OCP_OFF:      pin_nxt = gpio_out_i;
                ocp_pkg::OCP_ONE_LOW:  pin_nxt = 1'b0;
                ocp_pkg::OCP_ONE_HIGH: pin_nxt = 1'b1;
                ocp_pkg::OCP_TOGGLE:   pin_nxt = pin_r;
                ocp_pkg::OCP_DELAYED,
                ocp_pkg::OCP_CONT:     pin_nxt = 1'b0;
                ocp_pkg::OCP_PWM,
                ocp_pkg::OCP_PWM_FLT:  pin_nxt = (pri_r != '0);
            endcase
        end else begin
            unique case (ctl_r.mode)
                ocp_pkg::OCP_OFF: pin_nxt = gpio_out_i;
                ocp_pkg::OCP_ONE_LOW: begin
                    if (hit_pri && !done_r) begin
                        pin_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end
                end
                ocp_pkg::OCP_ONE_HIGH: begin
                    if (hit_pri && !done_r) begin
                        pin_nxt  = 1'b0;
                        done_nxt = 1'b1;
                    end
                end
                ocp_pkg::OCP_TOGGLE: begin
                    if (hit_pri) begin
                        pin_nxt = ~pin_r;
                    end
                end
                ocp_pkg::OCP_DELAYED, ocp_pkg::OCP_CONT: begin
                    // delayed stops after one pulse, continuous repeats
                    if (hit_pri && !done_r) begin
                        pin_nxt = 1'b1;
                    end else if (hit_sec && pin_r) begin
                        pin_nxt  = 1'b0;
                        done_nxt = (ctl_r.mode == ocp_pkg::OCP_DELAYED);
                    end
                end
                ocp_pkg::OCP_PWM, ocp_pkg::OCP_PWM_FLT: begin
                    // period boundary is the timer wrapping, duty is primary
                    if (fault_act) begin
                        pin_nxt = 1'b0;
                    end else if (run && tmr == '0) begin
                        pin_nxt = (pri_r != '0);
                    end else if (hit_pri) begin
                        pin_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    // edge detect on the driven pin level
    ocp_edge u_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (pin_r),
        .init_i (init_r),
        .rise_o (pin_rise),
        .fall_o (pin_fall)
    );

    // event choice per mode; entry edges are not events
    always_comb begin
        ev_match = 1'b0;
        unique case (ctl_r.mode)
            ocp_pkg::OCP_ONE_LOW:  ev_match = pin_rise;
            ocp_pkg::OCP_ONE_HIGH,
            ocp_pkg::OCP_DELAYED,
            ocp_pkg::OCP_CONT:     ev_match = pin_fall;
            ocp_pkg::OCP_TOGGLE:   ev_match = pin_rise | pin_fall;
            default:               ev_match = 1'b0;
        endcase
    end
    assign ev_fault = (ctl_r.mode == ocp_pkg::OCP_PWM_FLT) & fault_r & ~fault_input_a_n_i;

    // registers and bus answer
    always_comb begin
        ctl_nxt = ctl_r;
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        msk_nxt = msk_r;
        sts_nxt = sts_r;
        ack_nxt = req;
        dat_nxt = dat_r;
        // fault flag follows the fault condition in fault pwm
        ctl_nxt.fault_flag = fault_act;
        if (wr && wb_sel_i[0] && wb_adr_i == A_CTL) begin
            ctl_nxt.timebase_select = wb_dat_i[ocp_pkg::CTL_TSEL_BIT];
            ctl_nxt.mode            = ocp_pkg::ocp_mode_t'(wb_dat_i[2:0]);
        end
        if (wr && wb_sel_i[1] && wb_adr_i == A_CTL) begin
            ctl_nxt.idle_halt = wb_dat_i[ocp_pkg::CTL_IDLE_BIT];
        end
        if (wr && wb_adr_i == A_PRI) begin
            if (wb_sel_i[0]) pri_nxt[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) pri_nxt[15:8] = wb_dat_i[15:8];
        end
        if (wr && wb_adr_i == A_SEC) begin
            if (wb_sel_i[0]) sec_nxt[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) sec_nxt[15:8] = wb_dat_i[15:8];
        end
        if (wr && wb_sel_i[0] && wb_adr_i == A_MSK) begin
            msk_nxt = wb_dat_i[1:0];
        end
        // clear by writing one, a same-cycle event wins
        if (wr && wb_sel_i[0] && wb_adr_i == A_STS) begin
            sts_nxt = sts_r & ~wb_dat_i[1:0];
        end
        sts_nxt[ocp_pkg::ST_MATCH_BIT] = sts_nxt[ocp_pkg::ST_MATCH_BIT] | ev_match;
        sts_nxt[ocp_pkg::ST_FAULT_BIT] = sts_nxt[ocp_pkg::ST_FAULT_BIT] | ev_fault;
        if (rd) begin
            unique case (wb_adr_i)
                A_CTL:   dat_nxt = {16'h0000, 2'b00, ctl_r.idle_halt, 8'h00,
                                    ctl_r.fault_flag, ctl_r.timebase_select, ctl_r.mode};
                A_PRI:   dat_nxt = {16'h0000, pri_r};
                A_SEC:   dat_nxt = {16'h0000, sec_r};
                A_STS:   dat_nxt = {30'h0, sts_r};
                A_MSK:   dat_nxt = {30'h0, msk_r};
                default: dat_nxt = 32'h00000000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r       <= '0;  // every implemented control bit resets low
            pri_r       <= '0;
            sec_r       <= '0;
            sts_r       <= ocp_pkg::ST_RESET;
            msk_r       <= 2'b00;
            ack_r       <= 1'b0;
            dat_r       <= 32'h00000000;
            pin_r       <= 1'b0;
            done_r      <= 1'b0;
            init_r      <= 1'b1;
            mode_prev_r <= 3'h0;
            fault_r     <= 1'b1;
        end else begin
            ctl_r       <= ctl_nxt;
            pri_r       <= pri_nxt;
            sec_r       <= sec_nxt;
            sts_r       <= sts_nxt;
            msk_r       <= msk_nxt;
            ack_r       <= ack_nxt;
            dat_r       <= dat_nxt;
            pin_r       <= pin_nxt;
            done_r      <= done_nxt;
            init_r      <= init_nxt;
            mode_prev_r <= ctl_r.mode;
            fault_r     <= fault_input_a_n_i;
        end
    end

    assign wb_ack_o             = ack_r;
    assign wb_dat_o             = dat_r;
    assign compare_output_pin_o = pin_r;
    assign irq_o                = |(sts_r & msk_r);

    // checks
    stl_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_act |=> ctl_r.fault_flag) else $error("fault flag not set");
    off_noirq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_r.mode == ocp_pkg::OCP_OFF) |-> !ev_match) else $error("event while off");
    pwm_noirq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_r.mode == ocp_pkg::OCP_PWM) |-> !ev_match && !ev_fault) else $error("pwm event");
    fault_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_fault |=> sts_r[ocp_pkg::ST_FAULT_BIT]) else $error("fault event lost");
    toggle_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_r.mode == ocp_pkg::OCP_TOGGLE && !entry && hit_pri) |=> pin_r != $past(pin_r))
        else $error("toggle missed");
    entry_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (entry && ctl_r.mode == ocp_pkg::OCP_ONE_LOW) |=> !pin_r) else $error("bad start");
    pwm_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (entry && ctl_r.mode == ocp_pkg::OCP_PWM) |=> pin_r == ($past(pri_r) != '0))
        else $error("pwm start");
    // a match on the first timer alone must leave the toggling pin alone while the second timer is selected
    tsel_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_r.mode == ocp_pkg::OCP_TOGGLE && !entry && ctl_r.timebase_select &&
         timer_a_i == pri_r && timer_b_i != pri_r) |=> $stable(pin_r))
        else $error("wrong timer");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : ocp_compare

/* File: rtl/ocp_edge.sv */
`timescale 1ns/1ns
// rising / falling edge detector on a synchronous level
module ocp_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic lvl_i,
    input  wire logic init_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic prev_r;  // level seen last cycle
    logic prev_nxt;

    // next value simply follows the level
    always_comb begin
        prev_nxt = lvl_i;
    end

    // reset loads the pin's own reset level, low, so no false edge follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise_o = lvl_i & ~prev_r & ~init_i;
    assign fall_o = ~lvl_i & prev_r & ~init_i;
endmodule : ocp_edge

/* File: rtl/ocp_pkg.sv */
package ocp_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [4:0] ADDR_CONTROL   = 5'h00;  // compare_control
    localparam logic [4:0] ADDR_PRIMARY   = 5'h04;  // primary_compare_value
    localparam logic [4:0] ADDR_SECONDARY = 5'h08;  // secondary_compare_value
    localparam logic [4:0] ADDR_STATUS    = 5'h0c;  // sticky event flags, write one to clear
    localparam logic [4:0] ADDR_MASK      = 5'h10;  // interrupt enables, same layout as status
    // control field positions
    localparam int CTL_IDLE_BIT  = 13;
    localparam int CTL_FAULT_BIT = 4;
    localparam int CTL_TSEL_BIT  = 3;
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] CTL_WR_MASK  = 16'h200f;  // writable bits 13, 3, 2..0
    // status / mask bit positions
    localparam int ST_MATCH_BIT = 0;  // mode-selected pin edge event
    localparam int ST_FAULT_BIT = 1;  // fault input falling edge
    localparam logic [1:0] ST_RESET = 2'h0;

    // compare modes
    typedef enum logic [2:0] {
        OCP_OFF      = 3'h0,
        OCP_ONE_LOW  = 3'h1,
        OCP_ONE_HIGH = 3'h2,
        OCP_TOGGLE   = 3'h3,
        OCP_DELAYED  = 3'h4,
        OCP_CONT     = 3'h5,
        OCP_PWM      = 3'h6,
        OCP_PWM_FLT  = 3'h7
    } ocp_mode_t;

    // control register layout as a packed struct
    typedef struct packed {
        logic       idle_halt;
        logic       fault_flag;
        logic       timebase_select;
        ocp_mode_t  mode;
    } ocp_ctl_t;
endpackage : ocp_pkg
